// ==== verilog/mme_pkg.sv ====
package mme_pkg;

  // clocks and link rates
  localparam int         CLK_HZ      = 20_000_000;
  localparam int         EXT_CLK_HZ  = 9_830_400;
  localparam int         BUS_EXT_HZ  = 2_457_600;
  localparam int         BUS_INT_HZ  = 3_200_000;
  localparam int         LINK_BAUD   = 9600;
  localparam int         DIV_W       = 9;
  localparam logic [8:0] DIV_EXT     = 9'h100;
  localparam logic [8:0] DIV_INT     = 9'h14F;

  // link sequence lengths in bytes and bit times
  localparam int         SEC_BYTES   = 8;
  localparam int         BREAK_BITS  = 10;
  localparam int         GAP_BITS    = 2;
  localparam int         FRAME_BITS  = 10;

  // register map
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_CFG2   = 12'h004;
  localparam logic [11:0] ADDR_RXDATA = 12'h008;

  // second configuration register fields
  localparam int         CFG_IRQ_EN_BIT  = 0;
  localparam int         CFG_ALT_RST_BIT = 1;
  localparam int         CFG_ALT_OSC_BIT = 2;
  localparam logic [2:0] CFG2_RESET      = 3'h0;

  // status field positions
  localparam int         ST_MODE_LSB  = 0;
  localparam int         ST_CLKI_BIT  = 3;
  localparam int         ST_HV_BIT    = 4;
  localparam int         ST_HVG_BIT   = 5;
  localparam int         ST_LINK_LSB  = 6;
  localparam int         ST_SEC_LSB   = 12;

  typedef enum logic [2:0] {
    MODE_USER   = 3'h1,
    MODE_NORMAL = 3'h2,
    MODE_FORCED = 3'h4
  } mme_mode_t;

  typedef enum logic [5:0] {
    LS_OFF   = 6'h01,
    LS_SEC   = 6'h02,
    LS_BRK   = 6'h04,
    LS_READY = 6'h08,
    LS_GAP   = 6'h10,
    LS_ECHO  = 6'h20
  } mme_link_t;

endpackage : mme_pkg

// ==== verilog/mme_bit_timer.sv ====
`timescale 1ns/1ps
module mme_bit_timer
  import mme_pkg::*;
#(
  parameter int W = DIV_W
)(
  // clock and reset
  input  wire logic         I_CLK,
  input  wire logic         I_RST_N,
  // control
  input  wire logic         i_restart,
  input  wire logic [W-1:0] i_div,
  // ticks
  output logic              o_tick,
  output logic              o_mid
);

  logic [W-1:0] cnt;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      cnt <= '0;
    else if (i_restart || o_tick)
      cnt <= '0;
    else
      cnt <= cnt + 1'b1;
  end

  assign o_tick = !i_restart && (cnt == i_div - 1'b1);
  assign o_mid  = !i_restart && (cnt == (i_div >> 1));

endmodule : mme_bit_timer

// ==== verilog/mme_monitor_entry.sv ====
`timescale 1ns/1ps
module mme_monitor_entry
  import mme_pkg::*;
(
  // clock and resets
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_POR_N,
  // entry conditions
  input  wire logic        I_HV_TEST,
  input  wire logic        I_IRQ_LEVEL,
  input  wire logic        I_VECTOR_BLANK,
  input  wire logic        I_MODE_SEL_A,
  input  wire logic        I_MODE_SEL_B,
  input  wire logic [7:0]  I_TRIM_VALUE,
  // serial link pin
  input  wire logic        I_LINK_IN,
  output logic             O_LINK_OUT,
  output logic             O_LINK_OE,
  // mode, clock, watchdog and pin routing outputs
  output logic [2:0]       O_MODE,
  output logic             O_CLK_INT_SEL,
  output logic [7:0]       O_OSC_TRIM,
  output logic [8:0]       O_BAUD_DIV,
  output logic             O_WDOG_DIS,
  output logic             O_ALT_RST_EN,
  output logic             O_ALT_OSC_EN,
  output logic             O_IRQ_BRANCH_PIN,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic             O_PREADY,
  output logic [31:0]      O_PRDATA,
  output logic             O_PSLVERR
);

  logic        latched;
  logic        forced_keep;
  mme_mode_t   mode;
  mme_mode_t   next_mode;
  logic        clk_int;
  logic [8:0]  baud_div;
  logic        wdog_dis;
  logic [2:0]  cfg2;
  logic        hv_gone;
  logic [1:0]  route_held;
  logic        alt_rst;
  logic        alt_osc;
  logic        irq_pin;

  // mode decision at reset release
  always_comb
  begin
    if (forced_keep)
      next_mode = MODE_FORCED;
    else if (I_HV_TEST && I_MODE_SEL_A && !I_MODE_SEL_B)
      next_mode = MODE_NORMAL;
    else if (I_VECTOR_BLANK && !I_HV_TEST)
      next_mode = MODE_FORCED;
    else
      next_mode = MODE_USER;
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      latched <= 1'b0;
    else
      latched <= 1'b1;
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      mode     <= MODE_USER;
      clk_int  <= 1'b0;
      baud_div <= DIV_EXT;
    end
    else if (!latched)
    begin
      mode     <= next_mode;
      clk_int  <= (next_mode == MODE_FORCED) && !I_IRQ_LEVEL;
      baud_div <= ((next_mode == MODE_FORCED) && !I_IRQ_LEVEL) ? DIV_INT : DIV_EXT;
    end
  end

  // trim is caught once after release
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      O_OSC_TRIM <= 8'h00;
    else if (!latched)
      O_OSC_TRIM <= I_TRIM_VALUE;
  end

  // forced mode survives any reset but power-on
  always_ff @(posedge I_CLK or negedge I_POR_N)
  begin
    if (!I_POR_N)
      forced_keep <= 1'b0;
    else if (latched && mode == MODE_FORCED)
      forced_keep <= 1'b1;
  end

  // watchdog disable
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      wdog_dis <= 1'b0;
    else
      wdog_dis <= latched && ((mode == MODE_FORCED) ||
                  (mode == MODE_NORMAL && I_HV_TEST));
  end

  // pin routing in normal monitor mode
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      hv_gone    <= 1'b0;
      route_held <= 2'h0;
    end
    else if (latched && mode == MODE_NORMAL && !hv_gone && !I_HV_TEST)
    begin
      hv_gone    <= 1'b1;
      route_held <= {cfg2[CFG_ALT_OSC_BIT], cfg2[CFG_ALT_RST_BIT]};
    end
  end

  always_comb
  begin
    alt_rst = cfg2[CFG_ALT_RST_BIT];
    alt_osc = cfg2[CFG_ALT_OSC_BIT];
    irq_pin = cfg2[CFG_IRQ_EN_BIT];
    if (mode == MODE_NORMAL && !hv_gone && I_HV_TEST)
    begin
      alt_rst = 1'b1;
      alt_osc = 1'b1;
      irq_pin = 1'b1;
    end
    else if (mode == MODE_NORMAL)
    begin
      alt_rst = hv_gone ? route_held[0] : cfg2[CFG_ALT_RST_BIT];
      alt_osc = hv_gone ? route_held[1] : cfg2[CFG_ALT_OSC_BIT];
      irq_pin = cfg2[CFG_IRQ_EN_BIT];
    end
    else if (mode == MODE_FORCED)
    begin
      alt_osc = !clk_int;
      irq_pin = 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_ALT_RST_EN     <= 1'b0;
      O_ALT_OSC_EN     <= 1'b0;
      O_IRQ_BRANCH_PIN <= 1'b0;
    end
    else
    begin
      O_ALT_RST_EN     <= latched && alt_rst;
      O_ALT_OSC_EN     <= latched && alt_osc;
      O_IRQ_BRANCH_PIN <= latched && irq_pin;
    end
  end

  assign O_MODE        = mode;
  assign O_CLK_INT_SEL = clk_int;
  assign O_BAUD_DIV    = baud_div;
  assign O_WDOG_DIS    = wdog_dis;

  // receiver
  mme_link_t   link_state;
  mme_link_t   next_link_state;
  logic        link_prev;
  logic        rx_busy;
  logic [3:0]  rx_idx;
  logic [8:0]  rx_shift;
  logic        rx_done;
  logic        rx_break;
  logic [7:0]  rx_data;
  logic        rx_start;
  logic        rx_mid;
  logic        tx_tick;
  logic        tx_run;
  logic [3:0]  tx_cnt;
  logic [3:0]  next_tx_cnt;
  logic [3:0]  sec_cnt;
  logic        rx_allow;

  assign rx_allow = link_state == LS_SEC || link_state == LS_READY;
  assign rx_start = rx_allow && !rx_busy && link_prev && !I_LINK_IN;

  mme_bit_timer #(.W(DIV_W)) u_rx_timer (
    .I_CLK     (I_CLK),
    .I_RST_N   (I_RST_N),
    .i_restart (rx_start),
    .i_div     (baud_div),
    .o_tick    (),
    .o_mid     (rx_mid)
  );

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      link_prev <= 1'b1;
    else
      link_prev <= I_LINK_IN;
  end

  // NRZ frame sampled mid-bit, LSB first
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rx_busy  <= 1'b0;
      rx_idx   <= 4'h0;
      rx_shift <= 9'h000;
    end
    else if (rx_start)
    begin
      rx_busy <= 1'b1;
      rx_idx  <= 4'h0;
    end
    else if (rx_busy && rx_mid)
    begin
      rx_idx <= rx_idx + 4'h1;
      if (rx_idx != 4'h0)
        rx_shift <= {I_LINK_IN, rx_shift[8:1]};
      if (rx_idx == 4'(FRAME_BITS - 1))
        rx_busy <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      rx_done <= 1'b0;
    else
      rx_done <= rx_busy && rx_mid && rx_idx == 4'(FRAME_BITS - 1);
  end

  assign rx_break = rx_shift == 9'h000;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      rx_data <= 8'h00;
    else if (rx_done && rx_shift[8])
      rx_data <= rx_shift[7:0];
  end

  // link sequencer
  assign tx_run = link_state == LS_BRK || link_state == LS_GAP || link_state == LS_ECHO;

  mme_bit_timer #(.W(DIV_W)) u_tx_timer (
    .I_CLK     (I_CLK),
    .I_RST_N   (I_RST_N),
    .i_restart (!tx_run),
    .i_div     (baud_div),
    .o_tick    (tx_tick),
    .o_mid     ()
  );

  always_comb
  begin
    next_link_state = link_state;
    next_tx_cnt     = tx_cnt;
    if (tx_run && tx_tick)
      next_tx_cnt = tx_cnt - 4'h1;
    case (link_state)
      LS_OFF:
        if (latched && mode != MODE_USER)
          next_link_state = LS_SEC;
      LS_SEC:
        if (rx_done && rx_shift[8] && sec_cnt == 4'(SEC_BYTES - 1))
        begin
          next_link_state = LS_BRK;
          next_tx_cnt     = 4'(BREAK_BITS);
        end
      LS_BRK:
        if (tx_tick && tx_cnt == 4'h1)
          next_link_state = LS_READY;
      LS_READY:
        if (rx_done && rx_break)
        begin
          next_link_state = LS_GAP;
          next_tx_cnt     = 4'(GAP_BITS);
        end
      LS_GAP:
        if (tx_tick && tx_cnt == 4'h1)
        begin
          next_link_state = LS_ECHO;
          next_tx_cnt     = 4'(BREAK_BITS);
        end
      LS_ECHO:
        if (tx_tick && tx_cnt == 4'h1)
          next_link_state = LS_READY;
      default:
        next_link_state = LS_OFF;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      link_state <= LS_OFF;
      tx_cnt     <= 4'h0;
      O_LINK_OE  <= 1'b0;
    end
    else
    begin
      link_state <= next_link_state;
      tx_cnt     <= next_tx_cnt;
      O_LINK_OE  <= next_link_state == LS_BRK || next_link_state == LS_ECHO;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      sec_cnt <= 4'h0;
    else if (link_state == LS_SEC && rx_done && rx_shift[8])
      sec_cnt <= sec_cnt + 4'h1;
  end

  assign O_LINK_OUT = 1'b0;

  // apb slave, zero wait states
  logic        apb_setup;
  logic        apb_write;
  logic [31:0] rd_word;
  logic        addr_ok;

  assign apb_setup = I_PSEL && !I_PENABLE;
  assign apb_write = I_PSEL && I_PENABLE && I_PWRITE;
  assign addr_ok   = I_PADDR == ADDR_STATUS || I_PADDR == ADDR_CFG2 || I_PADDR == ADDR_RXDATA;
  assign O_PREADY  = I_PSEL && I_PENABLE;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (I_PADDR == ADDR_STATUS)
    begin
      rd_word[ST_MODE_LSB +: 3] = mode;
      rd_word[ST_CLKI_BIT]      = clk_int;
      rd_word[ST_HV_BIT]        = I_HV_TEST;
      rd_word[ST_HVG_BIT]       = hv_gone;
      rd_word[ST_LINK_LSB +: 6] = link_state;
      rd_word[ST_SEC_LSB +: 4]  = sec_cnt;
    end
    else if (I_PADDR == ADDR_CFG2)
      rd_word[2:0] = cfg2;
    else if (I_PADDR == ADDR_RXDATA)
      rd_word[7:0] = rx_data;
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_PRDATA  <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end
    else if (apb_setup)
    begin
      O_PRDATA  <= I_PWRITE ? 32'h0000_0000 : rd_word;
      O_PSLVERR <= !addr_ok;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      cfg2 <= CFG2_RESET;
    else if (apb_write && I_PADDR == ADDR_CFG2)
      cfg2 <= I_PWDATA[2:0];
  end

  // checks
  logic [15:0] oe_cycles;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      oe_cycles <= 16'h0000;
    else
      oe_cycles <= O_LINK_OE ? oe_cycles + 16'h0001 : 16'h0000;
  end

  AST_MODE_HELD: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    latched && $past(latched) |-> $stable(mode))
    else $error("mode changed after latch");

  AST_BLANK_FORCED: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_RST_N && !latched && I_VECTOR_BLANK && !I_HV_TEST |=> mode == MODE_FORCED)
    else $error("blank vector did not enter forced monitor");

  AST_PROG_USER: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_RST_N && !latched && !I_VECTOR_BLANK && !I_HV_TEST && !forced_keep |=> mode == MODE_USER)
    else $error("programmed vector entered monitor without test voltage");

  AST_INT_CLOCK: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_RST_N && !latched && !forced_keep && I_VECTOR_BLANK && !I_HV_TEST && !I_IRQ_LEVEL
    |=> clk_int && baud_div == DIV_INT)
    else $error("internal clock not selected");

  AST_EXT_DIV: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    latched && !clk_int |-> baud_div == DIV_EXT)
    else $error("external clock divisor wrong");

  AST_BREAK_LEN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    $fell(O_LINK_OE) |-> oe_cycles == 16'({7'h00, baud_div} * 16'(BREAK_BITS)))
    else $error("break length not ten bit times");

  AST_SEC_QUIET: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    link_state == LS_SEC |-> !O_LINK_OE && sec_cnt < 4'(SEC_BYTES))
    else $error("link driven before security bytes");

  AST_GAP_ECHO: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    link_state == LS_READY && rx_done && rx_break |=> link_state == LS_GAP && !O_LINK_OE)
    else $error("break not followed by release gap");

  AST_WDOG_HV: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    latched && mode == MODE_NORMAL && I_HV_TEST |=> O_WDOG_DIS)
    else $error("watchdog on with test voltage");

  AST_WDOG_FORCED: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    latched && mode == MODE_FORCED |=> O_WDOG_DIS)
    else $error("watchdog on in forced mode");

  AST_KEEP_FORCED: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_RST_N && !latched && forced_keep |=> mode == MODE_FORCED)
    else $error("warm reset left forced mode");

  AST_ALT_ROUTE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    latched && mode == MODE_NORMAL && I_HV_TEST && !hv_gone |=> O_ALT_RST_EN && O_ALT_OSC_EN)
    else $error("alternate pins not routed under test voltage");

  AST_ROUTE_FROZEN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    hv_gone && $past(hv_gone) && mode == MODE_NORMAL |=> $stable(O_ALT_RST_EN))
    else $error("pin routing moved after test voltage removal");

  AST_IRQ_BRANCH: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    latched && mode == MODE_NORMAL && hv_gone |=> O_IRQ_BRANCH_PIN == $past(cfg2[CFG_IRQ_EN_BIT]))
    else $error("branch pin sampling ignores enable bit");

endmodule : mme_monitor_entry

// ==== bench/mme_host_model.sv ====
`timescale 1ns/1ps
module mme_host_model (
  // clock
  input  wire logic I_CLK,
  // link drive, pullup gives the high level when released
  output logic      o_drive_low
);
  initial o_drive_low = 1'b0;

  // one frame: start, eight data bits lsb first, stop, then release
  task automatic send_frame(input logic [7:0] data, input logic stop, input int div);
    logic [9:0] bits;
    begin
      bits = {stop, data, 1'b0};
      for (int n = 0; n < 10; n++)
      begin
        @(posedge I_CLK);
        o_drive_low <= ~bits[n];
        repeat (div - 1) @(posedge I_CLK);
      end
      @(posedge I_CLK);
      o_drive_low <= 1'b0;
    end
  endtask : send_frame
endmodule : mme_host_model

// ==== bench/mme_monitor_entry_tb_top.sv ====
`timescale 1ns/1ps
module mme_monitor_entry_tb_top;
  import mme_pkg::*;
  localparam int LIMIT = 90000;
  logic        clk = 1'b0;
  logic        rst_n, por_n, hv, irq, blank, sel_a, sel_b;
  logic [7:0]  trim, osc_trim, b;
  logic        psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        link_oe, link_out, clk_int, wdog, alt_rst, alt_osc, irq_br, host_low, link;
  logic [2:0]  mode, v;
  logic [8:0]  baud;
  int          failures = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          oe_run = 0;
  int          oe_last = 0;
  int          oe_total = 0;
  int          oe_runs = 0;
  int          g, prev;

  // wired-or link with pullup
  assign link = ~(link_oe | host_low);
  always #25 clk = ~clk;

  mme_monitor_entry dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_POR_N(por_n), .I_HV_TEST(hv),
    .I_IRQ_LEVEL(irq), .I_VECTOR_BLANK(blank), .I_MODE_SEL_A(sel_a),
    .I_MODE_SEL_B(sel_b), .I_TRIM_VALUE(trim), .I_LINK_IN(link),
    .O_LINK_OUT(link_out), .O_LINK_OE(link_oe), .O_MODE(mode), .O_CLK_INT_SEL(clk_int),
    .O_OSC_TRIM(osc_trim), .O_BAUD_DIV(baud), .O_WDOG_DIS(wdog), .O_ALT_RST_EN(alt_rst),
    .O_ALT_OSC_EN(alt_osc), .O_IRQ_BRANCH_PIN(irq_br), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
    .O_PRDATA(prdata), .O_PSLVERR(pslverr)
  );

  mme_host_model host (
    .I_CLK(clk),
    .o_drive_low(host_low)
  );

  // length of each stretch the device pulls the link low
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (link_oe === 1'b1)
    begin
      oe_run <= oe_run + 1;
      oe_total <= oe_total + 1;
    end
    else if (oe_run != 0)
    begin
      oe_last <= oe_run;
      oe_runs <= oe_runs + 1;
      oe_run <= 0;
    end
    if (cyc >= LIMIT)
    begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
        @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic do_reset(input logic power_on);
    @(posedge clk);
    rst_n <= 1'b0;
    por_n <= ~power_on;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  // reference mode decision
  function automatic logic [2:0] exp_mode(input logic h, a, s, bl, fm);
    return fm ? MODE_FORCED : h ? ((a && !s) ? MODE_NORMAL : MODE_USER)
                                : (bl ? MODE_FORCED : MODE_USER);
  endfunction : exp_mode

  task automatic check_mode(input logic fm);
    logic [2:0] em;
    logic       ci;
    begin
      em = exp_mode(hv, sel_a, sel_b, blank, fm);
      ci = (em == MODE_FORCED) && !irq;
      chk("mode", mode, em);
      chk("clk_int", clk_int, ci);
      chk("div", baud, ci ? DIV_INT : DIV_EXT);
      chk("wdog", wdog, em != MODE_USER);
      if (ci)
        chk("trim", osc_trim, trim);
      if (em != MODE_USER)
        chk("brpin", irq_br, 1'b1);
      if (em == MODE_NORMAL)
        chk("alt", {alt_rst, alt_osc}, 2'h3);
      if (em == MODE_FORCED)
        chk("alt_osc", alt_osc, irq);
    end
  endtask : check_mode

  task automatic wait_runs(input int p);
    g = 0;
    while (oe_runs == p && g < 6000)
    begin
      @(posedge clk);
      g++;
    end
  endtask : wait_runs

  initial
  begin
    rst_n = 1'b0;
    por_n = 1'b0;
    {hv, irq, blank, sel_a, sel_b, psel, penable, pwrite} = 8'h40;
    trim = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(29908));
    for (int i = 0; i < 8; i++)
    begin
      hv <= i[0];
      blank <= i[1];
      irq <= i[2];
      sel_a <= 1'($urandom);
      sel_b <= 1'($urandom);
      trim <= 8'($urandom);
      do_reset(1'b1);
      check_mode(1'b0);
      sel_a <= ~sel_a;
      sel_b <= ~sel_b;
      repeat (2) @(posedge clk);
      chk("latched", mode, exp_mode(hv, ~sel_a, ~sel_b, blank, 1'b0));
    end
    // normal entry, then drop the test voltage
    hv <= 1'b1;
    sel_a <= 1'b1;
    sel_b <= 1'b0;
    blank <= 1'b0;
    irq <= 1'b1;
    do_reset(1'b1);
    check_mode(1'b0);
    apb(1'b0, ADDR_CFG2, 32'h0);
    chk("cfg2_rst", rd, {29'h0, CFG2_RESET});
    v = 3'($urandom);
    apb(1'b1, ADDR_CFG2, {29'h0, v});
    apb(1'b0, ADDR_CFG2, 32'h0);
    chk("cfg2", rd, {29'h0, v});
    chk("hv_on", {alt_rst, alt_osc, wdog}, 3'h7);
    hv <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wdog_off", wdog, 1'b0);
    chk("route", {alt_rst, alt_osc, irq_br}, {v[1], v[2], v[0]});
    apb(1'b1, ADDR_CFG2, {29'h0, ~v});
    repeat (2) @(posedge clk);
    chk("frozen", {alt_rst, alt_osc, irq_br, mode}, {v[1], v[2], ~v[0], MODE_NORMAL});
    apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", {rd[5:4], rd[2:0]}, {2'h2, MODE_NORMAL});
    apb(1'b0, 12'h00C, 32'h0);
    chk("err", er, 1'b1);
    chk("err_data", rd, 32'h0);
    // forced entry on internal clock, interrupt pin held low
    blank <= 1'b1;
    irq <= 1'b0;
    do_reset(1'b1);
    check_mode(1'b0);
    chk("link_pin", link_out, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("link_sec", rd[11:6], LS_SEC);
    for (int k = 0; k < SEC_BYTES; k++)
    begin
      b = 8'($urandom);
      host.send_frame(b, 1'b1, DIV_INT);
      if (k == SEC_BYTES - 2)
        chk("quiet", oe_total, 0);
    end
    wait_runs(0);
    chk("break", oe_last, BREAK_BITS * DIV_INT);
    apb(1'b0, ADDR_RXDATA, 32'h0);
    chk("rx", rd, {24'h0, b});
    prev = oe_runs;
    host.send_frame(8'h00, 1'b0, DIV_INT);
    g = 0;
    while (link_oe !== 1'b1 && g < 2000)
    begin
      @(posedge clk);
      g++;
    end
    chk("gap", (g > 5 * DIV_INT / 4) && (g < 7 * DIV_INT / 4), 1'b1);
    wait_runs(prev);
    chk("echo", oe_last, BREAK_BITS * DIV_INT);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("link_ready", rd[11:6], LS_READY);
    // warm reset keeps forced mode, power-on leaves it
    blank <= 1'b0;
    do_reset(1'b0);
    check_mode(1'b1);
    do_reset(1'b1);
    check_mode(1'b0);
    print_verdict();
  end
endmodule : mme_monitor_entry_tb_top
